// ---- inc/regwin_pkg.sv ----
// Package for the print mark window block: register map, fields, resets.
// Assumes a 32-bit register port with byte addresses on word boundaries.
package regwin_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_GATE_WIDTH = 8'h00;
    localparam logic [7:0] OFS_ABSENT_LIMIT = 8'h04;
    localparam logic [7:0] OFS_FIXED_RETURN = 8'h08;
    localparam logic [7:0] OFS_SYNC_SELECT = 8'h0C;
    localparam logic [7:0] OFS_REL_RETURN = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;
    localparam logic [7:0] OFS_MARK_POS = 8'h1C;
    localparam logic [7:0] OFS_MISS_COUNT = 8'h20;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    localparam logic [7:0] OFS_RETURN_RATE = 8'h2C;

    // ****************************************
    // Field widths and positions
    // ****************************************
    localparam int GATE_W = 16;
    localparam int LIMIT_W = 8;
    localparam int RATE_W = 24;
    localparam int SYNC_W = 8;
    localparam int REL_W = 16;
    localparam int POS_W = 32;
    localparam int REL_FRAC = 8;
    localparam int CTRL_EDGE_BIT = 0;
    localparam int STATE_TAUGHT_BIT = 0;
    localparam int STATE_MISSING_BIT = 1;
    localparam int STATE_SYNC_BIT = 2;
    localparam int STATE_ARMED_BIT = 3;
    localparam int IRQ_W = 4;
    localparam int IRQ_ACCEPT_BIT = 0;
    localparam int IRQ_REJECT_BIT = 1;
    localparam int IRQ_TEACH_BIT = 2;
    localparam int IRQ_MISSING_BIT = 3;

    // ****************************************
    // Limits and reset values
    // ****************************************
    localparam logic [GATE_W-1:0] GATE_MAX = 16'h270F;
    localparam logic [LIMIT_W-1:0] LIMIT_MAX = 8'h63;
    localparam logic [RATE_W-1:0] RATE_MAX = 24'h98967F;
    localparam logic [GATE_W-1:0] GATE_RST = 16'h0000;
    localparam logic [LIMIT_W-1:0] LIMIT_RST = 8'h00;
    localparam logic [RATE_W-1:0] FIXED_RST = 24'h000000;
    localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;
    localparam logic [REL_W-1:0] REL_RST = 16'h0100;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

    // ****************************************
    // Edge polarity encoding
    // ****************************************
    localparam logic EDGE_RISING = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;

endpackage

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous input pins.
// Assumes the pins are slow levels; a pulse shorter than a clock is kept only if it spans a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    // ****************************************
    // Synchroniser stages
    // ****************************************
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] level_reg;

    // First stage feeds only the second one
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            level_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            level_reg <= meta_reg;
        end
    end

    assign level_out = level_reg;

endmodule
`default_nettype wire

// ---- hw/mark_window_core.sv ----
// Print mark window, missing mark monitor, return speed and sync mode select.
// Assumes line_pos counts length units from the last sheet start, line_speed
// is the actual line speed, both on ref_clk; pins arrive asynchronously.
//
// Behaviour
// R1: The acceptance window reaches equally before and after the taught edge position.
// R2: Sensor edges outside the window are dropped; only edges inside register a mark.
// R3: The window position comes from the line position captured through the teach input.
// R4: Width 0..9999 is accepted and a width of zero lets every active edge register.
// R5: The operator raises teach before the mark reaches the sensor and creeps the line.
// R6: The operator drops teach before the next mark produces its edge.
// R7: Completed teaching stores the mark position and other marks no longer trigger.
// R8: Sheets without an accepted mark are counted and the missing output rises at the limit.
// R9: A limit of zero disables monitoring so the missing output stays low.
// R10: A nonzero fixed return rate sets the return speed regardless of line speed.
// R11: A zero fixed rate selects the relative setting scaled by the actual line speed.
// R12: While sync enable is high in the cutting phase, the selected sync profile is used.
// R13: The sync profile selection stays zero unless external clamping is in use.
// R14: Edge polarity 0 selects the rising sensor edge and 1 selects the falling edge.
// R15: An edge is accepted when line position lies within half the width of the mark position.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mark_window_core
    import regwin_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Pins
    input wire logic mark_sensor,
    input wire logic teach_mark,
    input wire logic sync_enable,
    // Line side, same clock
    input wire logic [POS_W-1:0] line_pos,
    input wire logic [RATE_W-1:0] line_speed,
    input wire logic sheet_start,
    input wire logic sync_phase,
    // Outputs
    output logic mark_hit,
    output logic mark_missing,
    output logic [RATE_W-1:0] return_rate,
    output logic sync_active,
    output logic [SYNC_W-1:0] sync_profile,
    output logic irq
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [POS_W-1:0] abs_diff(input logic [POS_W-1:0] a,
                                                 input logic [POS_W-1:0] b);
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction

    function automatic logic [7:0] word_addr(input logic [7:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic [2:0] pins_s;
    logic sensor_s;
    logic teach_s;
    logic sync_en_s;
    logic sensor_d_reg;
    logic active_edge;
    logic [GATE_W-1:0] gate_width_reg;
    logic [LIMIT_W-1:0] absent_limit_reg;
    logic [RATE_W-1:0] fixed_rate_reg;
    logic [SYNC_W-1:0] sync_select_reg;
    logic [REL_W-1:0] rel_rate_reg;
    logic edge_pol_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic [POS_W-1:0] mark_pos_reg;
    logic taught_reg;
    logic teach_armed_reg;
    logic teach_capture;
    logic in_window;
    logic accept;
    logic sheet_seen_reg;
    logic [LIMIT_W-1:0] miss_count_reg;
    logic [LIMIT_W-1:0] miss_count_next;
    logic missing_next;
    logic [RATE_W+REL_W-1:0] scaled;
    logic [RATE_W-1:0] rate_next;
    logic [7:0] wa;
    logic [31:0] rd_next;

    // ****************************************
    // Pin synchronisation and edge select
    // ****************************************
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in({sync_enable, teach_mark, mark_sensor}),
        .level_out(pins_s)
    );

    assign sensor_s = pins_s[0];
    assign teach_s = pins_s[1];
    assign sync_en_s = pins_s[2];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensor_d_reg <= 1'b0;
        end else begin
            sensor_d_reg <= sensor_s;
        end
    end

    always_comb begin
        if (edge_pol_reg == EDGE_FALLING) begin
            active_edge = sensor_d_reg & ~sensor_s; // R14
        end else begin
            active_edge = sensor_s & ~sensor_d_reg; // R14
        end
    end

    // ****************************************
    // Settings registers
    // ****************************************
    assign wa = word_addr(addr);

    // Out-of-range widths and limits are clamped so the window stays sane
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            gate_width_reg <= GATE_RST;
            absent_limit_reg <= LIMIT_RST;
            fixed_rate_reg <= FIXED_RST;
            sync_select_reg <= SYNC_RST;
            rel_rate_reg <= REL_RST;
            edge_pol_reg <= EDGE_RISING;
            irq_mask_reg <= IRQ_RST;
        end else if (wr_en) begin
            unique case (wa)
                OFS_GATE_WIDTH: begin
                    gate_width_reg <= (wr_data[GATE_W-1:0] > GATE_MAX) ?
                        GATE_MAX : wr_data[GATE_W-1:0]; // R4
                end
                OFS_ABSENT_LIMIT: begin
                    absent_limit_reg <= (wr_data[LIMIT_W-1:0] > LIMIT_MAX) ?
                        LIMIT_MAX : wr_data[LIMIT_W-1:0];
                end
                OFS_FIXED_RETURN: begin
                    fixed_rate_reg <= (wr_data[RATE_W-1:0] > RATE_MAX) ?
                        RATE_MAX : wr_data[RATE_W-1:0];
                end
                OFS_SYNC_SELECT: sync_select_reg <= wr_data[SYNC_W-1:0];
                OFS_REL_RETURN: rel_rate_reg <= wr_data[REL_W-1:0];
                OFS_CTRL: edge_pol_reg <= wr_data[CTRL_EDGE_BIT];
                OFS_IRQ_MASK: irq_mask_reg <= wr_data[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Teaching
    // ****************************************
    // One capture per teach pulse: later marks while teach stays high are
    // ignored, which is why the operator must drop teach before the next mark
    assign teach_capture = teach_s & teach_armed_reg & active_edge; // R5

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            teach_armed_reg <= 1'b0;
        end else if (!teach_s) begin
            teach_armed_reg <= 1'b1; // R6
        end else if (teach_capture) begin
            teach_armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mark_pos_reg <= '0;
            taught_reg <= 1'b0;
        end else if (teach_capture) begin
            mark_pos_reg <= line_pos; // R3 R7
            taught_reg <= 1'b1;
        end
    end

    // ****************************************
    // Window gating
    // ****************************************
    // Half width rounds down; without a taught position only a zero width lets edges pass
    always_comb begin
        in_window = taught_reg &&
            (abs_diff(line_pos, mark_pos_reg) <=
             POS_W'({1'b0, gate_width_reg[GATE_W-1:1]})); // R1 R15
        if (gate_width_reg == '0) begin
            accept = active_edge; // R4
        end else begin
            accept = active_edge & in_window & ~teach_s; // R2 R7
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mark_hit <= 1'b0;
        end else begin
            mark_hit <= accept; // R2
        end
    end

    // ****************************************
    // Missing mark monitor
    // ****************************************
    // A mark landing in the sheet-start cycle counts for the closing sheet
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sheet_seen_reg <= 1'b0;
        end else if (sheet_start) begin
            sheet_seen_reg <= 1'b0;
        end else if (accept) begin
            sheet_seen_reg <= 1'b1;
        end
    end

    always_comb begin
        miss_count_next = miss_count_reg;
        if (absent_limit_reg == '0) begin
            miss_count_next = '0; // R9
        end else if (sheet_start) begin
            if (sheet_seen_reg | accept) begin
                miss_count_next = '0;
            end else if (miss_count_reg < LIMIT_MAX) begin
                miss_count_next = miss_count_reg + LIMIT_W'(1); // R8
            end
        end
        missing_next = (absent_limit_reg != '0) &&
            (miss_count_next >= absent_limit_reg); // R8 R9
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            miss_count_reg <= '0;
            mark_missing <= 1'b0;
        end else begin
            miss_count_reg <= miss_count_next;
            mark_missing <= missing_next;
        end
    end

    // ****************************************
    // Return speed
    // ****************************************
    // Relative setting is a fixed-point factor; overflow saturates
    assign scaled = line_speed * rel_rate_reg;

    always_comb begin
        if (fixed_rate_reg != '0) begin
            rate_next = fixed_rate_reg; // R10
        end else if (|scaled[RATE_W+REL_W-1:RATE_W+REL_FRAC]) begin
            rate_next = '1; // R11
        end else begin
            rate_next = scaled[RATE_W+REL_FRAC-1:REL_FRAC]; // R11
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            return_rate <= '0;
        end else begin
            return_rate <= rate_next;
        end
    end

    // ****************************************
    // Sync mode
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync_active <= 1'b0;
            sync_profile <= '0;
        end else begin
            sync_active <= sync_en_s & sync_phase; // R12
            sync_profile <= (sync_en_s & sync_phase) ? sync_select_reg : '0; // R12
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_event = {missing_next & ~mark_missing, teach_capture,
                        active_edge & ~accept, accept};
    assign irq_clear = (wr_en && wa == OFS_IRQ_STATUS) ? wr_data[IRQ_W-1:0] : '0;

    // New events win over a same-cycle clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_status_reg <= IRQ_RST;
        end else begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_status_reg & ~irq_clear) | irq_event) & irq_mask_reg);
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    always_comb begin
        rd_next = '0;
        unique case (wa)
            OFS_GATE_WIDTH: rd_next = 32'(gate_width_reg);
            OFS_ABSENT_LIMIT: rd_next = 32'(absent_limit_reg);
            OFS_FIXED_RETURN: rd_next = 32'(fixed_rate_reg);
            OFS_SYNC_SELECT: rd_next = 32'(sync_select_reg);
            OFS_REL_RETURN: rd_next = 32'(rel_rate_reg);
            OFS_CTRL: rd_next[CTRL_EDGE_BIT] = edge_pol_reg;
            OFS_STATE: begin
                rd_next[STATE_TAUGHT_BIT] = taught_reg;
                rd_next[STATE_MISSING_BIT] = mark_missing;
                rd_next[STATE_SYNC_BIT] = sync_active;
                rd_next[STATE_ARMED_BIT] = teach_armed_reg;
            end
            OFS_MARK_POS: rd_next = mark_pos_reg;
            OFS_MISS_COUNT: rd_next = 32'(miss_count_reg);
            OFS_IRQ_STATUS: rd_next = 32'(irq_status_reg);
            OFS_IRQ_MASK: rd_next = 32'(irq_mask_reg);
            OFS_RETURN_RATE: rd_next = 32'(return_rate);
            default: rd_next = '0;
        endcase
    end

    // Data stands one cycle after the strobe and is zero otherwise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_en ? rd_next : '0;
        end
    end

endmodule
`default_nettype wire

// ---- tb/line_model.sv ----
// Line model: sheet-relative encoder count, sheet pulse, mark sensor.
// Assumes the line creeps one length unit per clock while run is high.
`timescale 1ns/1ps
`default_nettype none
module line_model #(
    parameter int SHEET = 500,
    parameter int MARK_A = 100,
    parameter int MARK_B = 300,
    parameter int MARK_LEN = 40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Controls
    input wire logic run,
    input wire logic mark_en,
    input wire logic invert,
    // Line and sensor
    output logic [31:0] line_pos,
    output logic sheet_start,
    output logic mark_sensor
);
    logic on_a, on_b;
    assign on_a = line_pos >= MARK_A && line_pos < MARK_A + MARK_LEN;
    assign on_b = line_pos >= MARK_B && line_pos < MARK_B + MARK_LEN;
    // Invert models a sensor that reads low over a mark
    assign mark_sensor = (mark_en && (on_a || on_b)) ^ invert;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            line_pos <= 32'h0;
            sheet_start <= 1'b0;
        end else begin
            if (run) line_pos <= (line_pos == SHEET - 1) ? 32'h0 : line_pos + 32'h1;
            sheet_start <= run && line_pos == SHEET - 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/mark_window_checker.sv ----
// Checker of mark_window_core port timing, attached by bind.
// Assumes settings are shadowed from writes on the register port.
`timescale 1ns/1ps
`default_nettype none
module mark_window_checker
    import regwin_pkg::*;
(
    // Clock, reset, register port
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    // Pins, line side, outputs
    input wire logic teach_mark,
    input wire logic [RATE_W-1:0] line_speed,
    input wire logic sheet_start,
    input wire logic sync_phase,
    input wire logic mark_hit,
    input wire logic mark_missing,
    input wire logic [RATE_W-1:0] return_rate,
    input wire logic sync_active,
    input wire logic [SYNC_W-1:0] sync_profile,
    input wire logic irq
);
    // ****************
    // Shadow settings
    // ****************
    logic [31:0] lim_reg, fix_reg, rel_reg, sel_reg, wid_reg, msk_reg;
    logic [39:0] prod;
    logic [RATE_W-1:0] rel_rate;
    assign prod = (40'(line_speed) * 40'(rel_reg[15:0])) >> REL_FRAC;
    assign rel_rate = (|prod[39:24]) ? 24'hFFFFFF : prod[23:0];
    function automatic logic [31:0] sat(input logic [31:0] d, input logic [31:0] m);
        return (d > m) ? m : d;
    endfunction
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lim_reg <= 32'(LIMIT_RST);
            fix_reg <= 32'(FIXED_RST);
            rel_reg <= 32'(REL_RST);
            sel_reg <= 32'(SYNC_RST);
            wid_reg <= 32'(GATE_RST);
            msk_reg <= 32'(IRQ_RST);
        end else if (wr_en) begin
            case (addr[7:2])
                OFS_GATE_WIDTH[7:2]: wid_reg <= sat(wr_data, 32'(GATE_MAX));
                OFS_ABSENT_LIMIT[7:2]: lim_reg <= sat(wr_data, 32'(LIMIT_MAX));
                OFS_FIXED_RETURN[7:2]: fix_reg <= sat(wr_data, 32'(RATE_MAX));
                OFS_SYNC_SELECT[7:2]: sel_reg <= 32'(wr_data[7:0]);
                OFS_REL_RETURN[7:2]: rel_reg <= 32'(wr_data[15:0]);
                OFS_IRQ_MASK[7:2]: msk_reg <= 32'(wr_data[3:0]);
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence lone_hit_s;
        mark_hit ##1 !mark_hit;
    endsequence
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 32'h0)
        else $error("read data outside answer cycle");
    AST_RD_HOLE: assert property ($past(rd_en) && $past(addr) > 8'h2F |-> rd_data == 32'h0)
        else $error("unmapped read gave data");
    AST_HIT_PULSE: assert property (mark_hit |-> lone_hit_s)
        else $error("mark pulse too long");
    AST_HIT_TEACH: assert property (mark_hit && |$past(wid_reg) |-> !$past(teach_mark, 3))
        else $error("mark taken while teaching");
    AST_MISS_OFF: assert property (lim_reg == 0 && $past(lim_reg) == 0 |-> !mark_missing)
        else $error("missing alarm while disabled");
    AST_MISS_RISE: assert property ($rose(mark_missing)
        |-> $past(sheet_start) || $past(wr_en, 2)) else $error("missing alarm off a sheet edge");
    AST_FIXED: assert property ($past(rstn) && $past(fix_reg) != 0
        |-> return_rate == $past(fix_reg[23:0])) else $error("fixed rate not used");
    AST_REL: assert property ($past(rstn) && $past(fix_reg) == 0
        |-> return_rate == $past(rel_rate)) else $error("relative rate wrong");
    AST_SYNC: assert property (sync_active |-> $past(sync_phase))
        else $error("sync active outside cutting phase");
    AST_PROFILE: assert property (sync_profile == (sync_active ? $past(sel_reg[7:0]) : 8'h00))
        else $error("sync profile wrong");
    AST_IRQ_MASK: assert property (msk_reg == 0 && $past(msk_reg) == 0 |-> !irq)
        else $error("masked interrupt raised");
endmodule
bind mark_window_core mark_window_checker mark_window_checker_inst (.ref_clk, .rstn, .addr,
    .wr_data, .wr_en, .rd_en, .rd_data, .teach_mark, .line_speed, .sheet_start, .sync_phase,
    .mark_hit, .mark_missing, .return_rate, .sync_active, .sync_profile, .irq);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for mark_window_core with the line model.
// Assumes one 250 MHz clock; the line moves one length unit per clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import regwin_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic teach_mark = 1'b0;
    logic sync_enable = 1'b0;
    logic sync_phase = 1'b0;
    logic run = 1'b0;
    logic mark_en = 1'b1;
    logic invert = 1'b0;
    logic [RATE_W-1:0] line_speed = 24'h001234;
    logic [31:0] rd_data, line_pos, v, e;
    logic sheet_start, mark_sensor, mark_hit, mark_missing, sync_active, irq;
    logic [RATE_W-1:0] return_rate;
    logic [SYNC_W-1:0] sync_profile;
    int bad_count = 0;
    int samples_checked = 0;
    int hits = 0;
    logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0, 32'h8,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h1234};
    // Width in [31:16], polarity [8], sensor inversion [4], hits per three sheets [3:0]
    logic [31:0] cases [5] = '{32'h00140003, 32'h00000005, 32'h00000115, 32'h00140100,
        32'h00140113};
    mark_window_core mark_window_core_inst (.ref_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .mark_sensor, .teach_mark, .sync_enable, .line_pos, .line_speed,
        .sheet_start, .sync_phase, .mark_hit, .mark_missing, .return_rate, .sync_active,
        .sync_profile, .irq);
    line_model line_model_inst (.ref_clk, .rstn, .run, .mark_en, .invert, .line_pos,
        .sheet_start, .mark_sensor);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (mark_hit === 1'b1) hits++;
    function automatic logic [31:0] lim(input logic [31:0] d, input logic [31:0] m);
        return (d > m) ? m : d;
    endfunction
    function automatic logic [31:0] rate_exp(input logic [31:0] f, input logic [23:0] s,
        input logic [15:0] r);
        logic [39:0] p;
        p = (40'(s) * 40'(r)) >> 8;
        if (f != 0) return f;
        return (|p[39:24]) ? 32'hFFFFFF : 32'(p[23:0]);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rd_data;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(v, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_pos(input int p);
        @(posedge ref_clk iff line_pos == p);
    endtask
    task automatic sheets(input int n);
        repeat (n) @(posedge ref_clk iff sheet_start === 1'b1);
        wait_pos(250);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        v = $urandom(32'hDD81);
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rdc(8'(4 * i), rst_tab[i]);
        end
        wr(OFS_MARK_POS, 32'hFFFF);
        rdc(OFS_MARK_POS, 32'h0);
        rdc(8'h30, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            e = (i == 0) ? 32'hFFFFFFFF : $urandom;
            wr(OFS_GATE_WIDTH, 32'(e[15:0]));
            rdc(OFS_GATE_WIDTH, lim(32'(e[15:0]), 32'(GATE_MAX)));
            wr(OFS_ABSENT_LIMIT, 32'(e[7:0]));
            rdc(OFS_ABSENT_LIMIT, lim(32'(e[7:0]), 32'(LIMIT_MAX)));
            wr(OFS_REL_RETURN, 32'(e[15:0]));
            wr(OFS_FIXED_RETURN, i[0] ? 32'(e[23:0]) : 32'h0);
            line_speed <= e[31:8];
            tick(3);
            e = rate_exp(i[0] ? lim(32'(e[23:0]), 32'(RATE_MAX)) : 32'h0, e[31:8], e[15:0]);
            check(32'(return_rate), e);
        end
        $display("test return rate done");
        wr(OFS_ABSENT_LIMIT, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        run <= 1'b1;
        wait_pos(50);
        teach_mark <= 1'b1;
        wait_pos(200);
        teach_mark <= 1'b0;
        rd(OFS_MARK_POS);
        check(32'(v >= 100 && v <= 106), 32'h1);
        wr(OFS_IRQ_STATUS, 32'hF);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_GATE_WIDTH, 32'(cases[i][31:16]));
            wr(OFS_CTRL, 32'(cases[i][8]));
            invert <= cases[i][4];
            wait_pos(450);
            hits = 0;
            sheets(3);
            check(32'(hits), 32'(cases[i][3:0]));
            if (i == 0) begin
                rdc(OFS_IRQ_STATUS, 32'h3);
                check(32'(irq), 32'h1);
                wr(OFS_IRQ_STATUS, 32'h1);
                rdc(OFS_IRQ_STATUS, 32'h2);
                tick(1);
                check(32'(irq), 32'h0);
            end
        end
        $display("test window done");
        @(posedge ref_clk);
        mark_en <= 1'b0;
        wr(OFS_IRQ_MASK, 32'h8);
        sheets(1);
        wr(OFS_ABSENT_LIMIT, 32'h0);
        wr(OFS_ABSENT_LIMIT, 32'h2);
        sheets(1);
        check(32'(mark_missing), 32'h0);
        sheets(1);
        check(32'(mark_missing), 32'h1);
        check(32'(irq), 32'h1);
        rdc(OFS_MISS_COUNT, 32'h2);
        wr(OFS_ABSENT_LIMIT, 32'h0);
        sheets(1);
        check(32'(mark_missing), 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        tick(2);
        check(32'(irq), 32'h0);
        $display("test missing done");
        v = $urandom;
        wr(OFS_SYNC_SELECT, 32'(v[7:0]));
        for (int j = 0; j < 4; j++) begin
            @(posedge ref_clk);
            sync_enable <= j[0];
            sync_phase <= j[1];
            tick(6);
            check(32'(sync_active), 32'(j == 3));
            check(32'(sync_profile), (j == 3) ? 32'(v[7:0]) : 32'h0);
        end
        // Selection returns to zero: no clamping fitted
        wr(OFS_SYNC_SELECT, 32'h0);
        $display("test sync done");
        print_verdict();
    end
endmodule
`default_nettype wire
